// ==== hdl/crd_pkg.sv ====
// Purpose: Shared constants of the conversion rate clock divider.
// Assumes: 32-bit register port with byte addresses, one word per register.
// Notes: Channel registers are spaced one word apart from their base.
package crd_pkg;
	localparam int CRD_CHANNELS = 8;
	localparam int TRIM_W = 24;
	localparam int SAMPLE_W = 3;
	localparam int ACC_W = 16;
	localparam int WIDE_W = 32;
	localparam int PRE_W = 2;
	localparam int DEC_W = 3;
	localparam int PRE_CNT_W = 3;
	localparam int DEC_CNT_W = 12;
	localparam int STATUS_W = 2;
	localparam logic [7:0] ADDR_SETUP = 8'h00;
	localparam logic [7:0] ADDR_STATUS = 8'h04;
	localparam logic [7:0] ADDR_MASK = 8'h08;
	localparam logic [7:0] ADDR_DIVSTATE = 8'h0C;
	localparam logic [7:0] ADDR_OFFSET_BASE = 8'h10;
	localparam logic [7:0] ADDR_GAIN_BASE = 8'h30;
	localparam logic [7:0] ADDR_RESULT_BASE = 8'h50;
	localparam int SETUP_PRE_LSB = 0;
	localparam int SETUP_DEC_LSB = 2;
	localparam int STATUS_WORD_BIT = 0;
	localparam int STATUS_OVERRUN_BIT = 1;
	localparam logic [PRE_W-1:0] PRE_RESET = 2'h0;
	localparam logic [DEC_W-1:0] DEC_RESET = 3'h3;
	localparam logic [STATUS_W-1:0] MASK_RESET = 2'h0;
	localparam logic [PRE_CNT_W:0] PRE_ONE = 4'h1;
	localparam logic [DEC_CNT_W:0] RATIO_BASE = 13'h0020;
	localparam logic [1:0] SAMPLE_DIV_LAST = 2'h3;
	localparam logic [4:0] FULL_SCALE_SHIFT = 5'h11;
	localparam int GAIN_FRAC = 23;
endpackage : crd_pkg

// ==== hdl/crd_trim_channel.sv ====
// Purpose: One channel: sinc accumulate-and-dump, offset and gain trim.
// Assumes: Ticks come from the divider on the same clock.
// Notes: Gain is one plus the signed trim word over two to the 23.
`timescale 1ns/100ps
module crd_trim_channel
	import crd_pkg::*;
(
	input wire logic sys_clk,
	input wire logic sys_rst,
	input wire logic sampleTick,
	input wire logic wordTick,
	input wire logic [DEC_W-1:0] ratioCode,
	input wire logic [SAMPLE_W-1:0] modSample,
	input wire logic [TRIM_W-1:0] offsetTrim,
	input wire logic [TRIM_W-1:0] gainTrim,
	output logic [TRIM_W-1:0] result
);
	logic signed [ACC_W-1:0] acc_ff;
	logic signed [ACC_W-1:0] sampleExt;
	logic signed [ACC_W-1:0] finalSum;
	logic [4:0] shiftAmt;
	logic signed [WIDE_W-1:0] scaled;
	logic signed [WIDE_W-1:0] withOffset;
	logic signed [WIDE_W+TRIM_W-1:0] prodFull;
	logic signed [WIDE_W-1:0] gained;
	logic [TRIM_W-1:0] nxt_result;
	logic [TRIM_W-1:0] result_ff;

	assign sampleExt = {{(ACC_W-SAMPLE_W){modSample[SAMPLE_W-1]}}, modSample};
	assign finalSum = acc_ff + sampleExt;

	// A plain boxcar over one word gives the notches at multiples of the rate.
	always_ff @(posedge sys_clk) begin
		if (sys_rst) begin
			acc_ff <= '0;
		end else if (wordTick) begin
			acc_ff <= '0;
		end else if (sampleTick) begin
			acc_ff <= finalSum;
		end
	end

	// Scaling by ratio keeps full scale near the top of the 24-bit word.
	assign shiftAmt = FULL_SCALE_SHIFT - {2'h0, ratioCode};
	assign scaled = {{(WIDE_W-ACC_W){finalSum[ACC_W-1]}}, finalSum} <<< shiftAmt;
	assign withOffset = scaled +
		{{(WIDE_W-TRIM_W){offsetTrim[TRIM_W-1]}}, offsetTrim};
	assign prodFull = $signed({{TRIM_W{withOffset[WIDE_W-1]}}, withOffset}) *
		$signed({{WIDE_W{gainTrim[TRIM_W-1]}}, gainTrim});
	assign gained = withOffset + WIDE_W'(prodFull >>> GAIN_FRAC);

	// Saturation avoids a wrap from full positive to full negative scale.
	always_comb begin
		nxt_result = gained[TRIM_W-1:0];
		if (gained[WIDE_W-1] && !(&gained[WIDE_W-2:TRIM_W-1])) begin
			nxt_result = {1'b1, {(TRIM_W-1){1'b0}}};
		end else if (!gained[WIDE_W-1] && (|gained[WIDE_W-2:TRIM_W-1])) begin
			nxt_result = {1'b0, {(TRIM_W-1){1'b1}}};
		end
	end

	always_ff @(posedge sys_clk) begin
		if (sys_rst) begin
			result_ff <= '0;
		end else if (wordTick) begin
			result_ff <= nxt_result;
		end
	end

	assign result = result_ff;
endmodule : crd_trim_channel

// ==== hdl/crd_rate_divider.sv ====
// Purpose: Prescaler, divide-by-four and decimation divider with trims.
// Assumes: Modulator samples arrive from logic on sys_clk.
// Notes: The ready output is active low, as an interrupt pin would be.
// Function
// - One ready pulse per new result set.
// - Word rate is clock over four, ratio, prescale.
// - Prescale codes divide by one, two, four, eight.
// - Ratio is 32 shifted left by code.
// - Ratio selector resets to 256.
// - One word per ratio sample periods.
// - Sinc filter notches at word rate multiples.
// - Per-channel 24-bit offset trim correction.
// - Per-channel 24-bit gain trim correction.
// - Pulse lasts half a sample period, unlatched.
// - Sample clock is modulator clock over four.
//
// Design decisions made here: the strobed register port and the register addresses.
`timescale 1ns/100ps
module crd_rate_divider
	import crd_pkg::*;
#(
	parameter int CHANNELS = CRD_CHANNELS
) (
	input wire logic sys_clk,
	input wire logic sys_rst,
	input wire logic [7:0] regAddr,
	input wire logic [31:0] regWrData,
	input wire logic regWrStb,
	input wire logic regRdStb,
	output logic [31:0] regRdData,
	input wire logic [CHANNELS*SAMPLE_W-1:0] modSamples,
	output logic [CHANNELS*TRIM_W-1:0] channelResults,
	output logic modulatorTick,
	output logic sampleClock,
	output logic resultReadyPulseN,
	output logic irq
);
	// The channel address windows hold eight words each.
	if (CHANNELS < 1 || CHANNELS > 8) begin : gCheck
		$error("CHANNELS must be between 1 and 8");
	end

	logic [PRE_W-1:0] preCode_ff;
	logic [DEC_W-1:0] decCode_ff;
	logic [STATUS_W-1:0] status_ff;
	logic [STATUS_W-1:0] mask_ff;
	logic [STATUS_W-1:0] statusSet;
	logic [STATUS_W-1:0] nxt_status;
	logic [PRE_CNT_W-1:0] preCnt_ff;
	logic [PRE_CNT_W-1:0] preLimit;
	logic [1:0] quarterCnt_ff;
	logic [DEC_CNT_W-1:0] decCnt_ff;
	logic [DEC_CNT_W-1:0] ratioLimit;
	logic haveWord_ff;
	logic readyPulseN_ff;
	logic modTick;
	logic sampleTick;
	logic wordTick;
	logic [31:0] nxt_rdData;
	logic [31:0] rdData_ff;
	logic [TRIM_W-1:0] offTrim_ff [CHANNELS];
	logic [TRIM_W-1:0] gainTrim_ff [CHANNELS];
	logic [TRIM_W-1:0] results [CHANNELS];

	// Setup word: prescale and decimation ratio codes.
	always_ff @(posedge sys_clk) begin
		if (sys_rst) begin
			preCode_ff <= PRE_RESET;
			decCode_ff <= DEC_RESET;
		end else if (regWrStb && regAddr == ADDR_SETUP) begin
			preCode_ff <= regWrData[SETUP_PRE_LSB +: PRE_W];
			decCode_ff <= regWrData[SETUP_DEC_LSB +: DEC_W];
		end
	end

	always_ff @(posedge sys_clk) begin
		if (sys_rst) begin
			mask_ff <= MASK_RESET;
		end else if (regWrStb && regAddr == ADDR_MASK) begin
			mask_ff <= regWrData[STATUS_W-1:0];
		end
	end

	// Prescaler: wraps after 1, 2, 4 or 8 master clocks.
	assign preLimit = PRE_CNT_W'((PRE_ONE << preCode_ff) - PRE_ONE);
	// Comparing with at least the limit survives a code change mid-count.
	assign modTick = (preCnt_ff >= preLimit);

	always_ff @(posedge sys_clk) begin
		if (sys_rst) begin
			preCnt_ff <= '0;
		end else if (modTick) begin
			preCnt_ff <= '0;
		end else begin
			preCnt_ff <= preCnt_ff + 3'h1;
		end
	end

	// Fixed divide by four from modulator clock to sample clock.
	always_ff @(posedge sys_clk) begin
		if (sys_rst) begin
			quarterCnt_ff <= '0;
		end else if (modTick) begin
			quarterCnt_ff <= quarterCnt_ff + 2'h1;
		end
	end

	assign sampleTick = modTick && (quarterCnt_ff == SAMPLE_DIV_LAST);

	// Decimation divider: ratio sample periods per word.
	assign ratioLimit = DEC_CNT_W'((RATIO_BASE << decCode_ff) - 13'h0001);
	assign wordTick = sampleTick && (decCnt_ff >= ratioLimit);

	always_ff @(posedge sys_clk) begin
		if (sys_rst) begin
			decCnt_ff <= '0;
		end else if (wordTick) begin
			decCnt_ff <= '0;
		end else if (sampleTick) begin
			decCnt_ff <= decCnt_ff + 12'h001;
		end
	end

	// No pulse before the first full word after reset: nothing is ready yet.
	always_ff @(posedge sys_clk) begin
		if (sys_rst) begin
			haveWord_ff <= 1'b0;
		end else if (wordTick) begin
			haveWord_ff <= 1'b1;
		end
	end

	// Low during the first half of the first sample period of each word.
	always_ff @(posedge sys_clk) begin
		if (sys_rst) begin
			readyPulseN_ff <= 1'b1;
		end else begin
			readyPulseN_ff <= !(haveWord_ff && decCnt_ff == '0 &&
				!quarterCnt_ff[1]);
		end
	end

	assign resultReadyPulseN = readyPulseN_ff;
	assign sampleClock = quarterCnt_ff[1];
	assign modulatorTick = modTick;

	// Sticky events; a new event in the clearing read's cycle survives.
	assign statusSet[STATUS_WORD_BIT] = wordTick;
	assign statusSet[STATUS_OVERRUN_BIT] = wordTick && status_ff[STATUS_WORD_BIT];

	always_comb begin
		nxt_status = status_ff;
		if (regRdStb && regAddr == ADDR_STATUS) begin
			nxt_status = '0;
		end
		nxt_status = nxt_status | statusSet;
	end

	always_ff @(posedge sys_clk) begin
		if (sys_rst) begin
			status_ff <= '0;
		end else begin
			status_ff <= nxt_status;
		end
	end

	assign irq = |(status_ff & mask_ff);

	for (genvar ch = 0; ch < CHANNELS; ch++) begin : gChan
		always_ff @(posedge sys_clk) begin
			if (sys_rst) begin
				offTrim_ff[ch] <= '0;
			end else if (regWrStb && regAddr == ADDR_OFFSET_BASE + 8'(ch * 4)) begin
				offTrim_ff[ch] <= regWrData[TRIM_W-1:0];
			end
		end

		always_ff @(posedge sys_clk) begin
			if (sys_rst) begin
				gainTrim_ff[ch] <= '0;
			end else if (regWrStb && regAddr == ADDR_GAIN_BASE + 8'(ch * 4)) begin
				gainTrim_ff[ch] <= regWrData[TRIM_W-1:0];
			end
		end

		crd_trim_channel uChan (
			.sys_clk(sys_clk),
			.sys_rst(sys_rst),
			.sampleTick(sampleTick),
			.wordTick(wordTick),
			.ratioCode(decCode_ff),
			.modSample(modSamples[ch*SAMPLE_W +: SAMPLE_W]),
			.offsetTrim(offTrim_ff[ch]),
			.gainTrim(gainTrim_ff[ch]),
			.result(results[ch])
		);

		assign channelResults[ch*TRIM_W +: TRIM_W] = results[ch];
	end

	// Read decode; unmapped addresses read as zero.
	always_comb begin
		nxt_rdData = 32'h00000000;
		if (regAddr == ADDR_SETUP) begin
			nxt_rdData = {27'h0000000, decCode_ff, preCode_ff};
		end else if (regAddr == ADDR_STATUS) begin
			nxt_rdData = {30'h00000000, status_ff};
		end else if (regAddr == ADDR_MASK) begin
			nxt_rdData = {30'h00000000, mask_ff};
		end else if (regAddr == ADDR_DIVSTATE) begin
			nxt_rdData = {14'h0000, haveWord_ff, decCnt_ff, quarterCnt_ff,
				preCnt_ff};
		end
		for (int i = 0; i < CHANNELS; i++) begin
			if (regAddr == ADDR_OFFSET_BASE + 8'(i * 4)) begin
				nxt_rdData = {8'h00, offTrim_ff[i]};
			end else if (regAddr == ADDR_GAIN_BASE + 8'(i * 4)) begin
				nxt_rdData = {8'h00, gainTrim_ff[i]};
			end else if (regAddr == ADDR_RESULT_BASE + 8'(i * 4)) begin
				nxt_rdData = {8'h00, results[i]};
			end
		end
	end

	// Read data stands only in the cycle after the strobe.
	always_ff @(posedge sys_clk) begin
		if (sys_rst) begin
			rdData_ff <= 32'h00000000;
		end else if (regRdStb) begin
			rdData_ff <= nxt_rdData;
		end else begin
			rdData_ff <= 32'h00000000;
		end
	end

	assign regRdData = rdData_ff;
endmodule : crd_rate_divider

// ==== verification/crd_rate_divider_assertions.sv ====
// Purpose: Port checks for the rate divider.
// Assumes: One clock and a synchronous reset.
// Notes: Bounds are wide enough for every prescale code.
`timescale 1ns/100ps
module crd_rate_divider_assertions
	import crd_pkg::*;
#(
	parameter int CHANNELS = CRD_CHANNELS
) (
	input wire logic sys_clk,
	input wire logic sys_rst,
	input wire logic [CHANNELS*TRIM_W-1:0] channelResults,
	input wire logic modulatorTick,
	input wire logic sampleClock,
	input wire logic resultReadyPulseN,
	input wire logic irq
);
	wire rdyN = resultReadyPulseN;
	default clocking cb @(posedge sys_clk);
	endclocking
	default disable iff (sys_rst);
	chk_reset_quiet: assert property (
		$fell(sys_rst) |-> rdyN && !irq && channelResults == '0)
		else $error("Outputs busy after reset");
	chk_pulse_min: assert property ($fell(rdyN) |-> !rdyN[*2])
		else $error("Ready pulse short");
	chk_pulse_max: assert property ($fell(rdyN) |-> ##[2:16] rdyN)
		else $error("Ready pulse long");
	chk_pulse_gap: assert property ($rose(rdyN) |-> rdyN[*8])
		else $error("Ready pulses too close");
	chk_pulse_phase: assert property ($fell(rdyN) |-> !sampleClock)
		else $error("Ready pulse off phase");
	chk_tick_gap: assert property (
		!modulatorTick |-> ##[1:7] modulatorTick)
		else $error("Modulator tick late");
	chk_sample_step: assert property (
		$changed(sampleClock) |-> $past(modulatorTick))
		else $error("Sample clock moved off tick");
	chk_sample_half: assert property (
		$rose(sampleClock) |-> sampleClock[*2])
		else $error("Sample clock high too short");
	cover property ($fell(rdyN));
	cover property ($rose(irq));
	cover property ($rose(sampleClock));
endmodule : crd_rate_divider_assertions
bind crd_rate_divider crd_rate_divider_assertions #(.CHANNELS(CHANNELS))
	crd_rate_divider_assertions_i (.sys_clk, .sys_rst, .channelResults,
	.modulatorTick, .sampleClock, .resultReadyPulseN, .irq);

// ==== verification/crd_host_model.sv ====
// Purpose: Host that timestamps ready pulses.
// Assumes: Ready pin is active low on sys_clk.
// Notes: Gap is fall to fall, so a short first word is seen once.
`timescale 1ns/100ps
module crd_host_model (
	input wire logic sys_clk,
	input wire logic resultReadyPulseN,
	output int pulseCnt = 0,
	output int lowLen = 0,
	output int gapLen = 0
);
	int run = 0;
	int low = 0;
	logic last = 1'b1;
	always @(posedge sys_clk) begin
		last <= resultReadyPulseN;
		run <= run + 1;
		low <= low + 1;
		if (last && !resultReadyPulseN) begin
			pulseCnt <= pulseCnt + 1;
			gapLen <= run;
			run <= 1;
			low <= 1;
		end
		if (!last && resultReadyPulseN)
			lowLen <= low;
	end
endmodule : crd_host_model

// ==== verification/crd_rate_divider_tb_top.sv ====
// Purpose: Self-checking bench for the rate divider.
// Assumes: Host model watches the ready pin.
// Notes: Rates are timed fall to fall from the second pulse after a change.
`timescale 1ns/100ps
module crd_rate_divider_tb_top
	import crd_pkg::*;
;
	logic sys_clk = 1'b0;
	logic sys_rst = 1'b1;
	logic [7:0] regAddr = 8'h00;
	logic [31:0] regWrData = 32'h00000000;
	logic regWrStb = 1'b0;
	logic regRdStb = 1'b0;
	logic [23:0] modSamples = 24'h000000;
	logic [31:0] regRdData, rd;
	logic [191:0] channelResults;
	logic modulatorTick, sampleClock, resultReadyPulseN, irq;
	int pulseCnt, lowLen, gapLen;
	int error_cnt = 0;
	int compares = 0;
	initial begin
		forever #50 sys_clk = ~sys_clk;
	end
	crd_rate_divider crd_rate_divider_i (.sys_clk, .sys_rst, .regAddr,
		.regWrData, .regWrStb, .regRdStb, .regRdData, .modSamples,
		.channelResults, .modulatorTick, .sampleClock,
		.resultReadyPulseN, .irq);
	crd_host_model crd_host_model_i (.sys_clk, .resultReadyPulseN,
		.pulseCnt, .lowLen, .gapLen);
	task check(input logic [63:0] seen, input logic [63:0] exp);
		compares++;
		if (seen !== exp) begin
			error_cnt++;
			$display("CHECK FAILED %0t saw %0h want %0h", $time, seen, exp);
		end
	endtask : check
	task stop_test;
		if (error_cnt == 0 && compares > 0) $display("[ PASS ]");
		else $display("[ FAIL ]");
		$finish;
	endtask : stop_test
	task wr(input logic [7:0] a, input logic [31:0] d);
		@(posedge sys_clk);
		regAddr <= a;
		regWrData <= d;
		regWrStb <= 1'b1;
		@(posedge sys_clk);
		regWrStb <= 1'b0;
	endtask : wr
	task rdr(input logic [7:0] a);
		@(posedge sys_clk);
		regAddr <= a;
		regRdStb <= 1'b1;
		@(posedge sys_clk);
		regRdStb <= 1'b0;
		@(negedge sys_clk);
		rd = regRdData;
	endtask : rdr
	task waitp(input int n);
		int t;
		t = pulseCnt + n;
		for (int i = 0; i < 40000 && pulseCnt < t; i++) @(posedge sys_clk);
		if (pulseCnt < t) begin
			error_cnt++;
			stop_test();
		end
		@(negedge sys_clk);
	endtask : waitp
	task t_rates;
		int p;
		int c;
		for (int k = 0; k < 11; k++) begin
			p = k < 4 ? k : 0;
			c = k < 4 ? 0 : k - 3;
			wr(ADDR_SETUP, (c << 2) | p);
			waitp(2);
			check(gapLen, 4 * (1 << p) * (32 << c));
			check(lowLen, 2 * (1 << p));
		end
	endtask : t_rates
	task t_trims;
		longint x;
		wr(ADDR_SETUP, 32'h00000000);
		for (int n = 0; n < 8; n++) begin
			wr(ADDR_OFFSET_BASE + 8'(4 * n), 32'h00000100 * (n + 1));
			wr(ADDR_GAIN_BASE + 8'(4 * n), n == 3 ? 32'h00400000 : 32'h0);
		end
		modSamples <= {8{3'h1}};
		waitp(2);
		for (int n = 0; n < 8; n++) begin
			x = 64'h400000 + 64'h100 * (n + 1);
			x = n == 3 ? x + (x >>> 1) : x;
			check(channelResults[n * 24 +: 24], x);
		end
		rdr(ADDR_RESULT_BASE + 8'h0C);
		check(rd, 32'h00600600);
		@(posedge sys_clk);
		modSamples <= 24'h000000;
	endtask : t_trims
	task t_irq;
		wr(ADDR_MASK, 32'h00000000);
		waitp(1);
		check(irq, 1'b0);
		rdr(ADDR_STATUS);
		check(rd[STATUS_WORD_BIT], 1'b1);
		check(rd[STATUS_OVERRUN_BIT], 1'b1);
		rdr(ADDR_STATUS);
		check(rd, 32'h00000000);
		wr(ADDR_MASK, 32'h00000001);
		waitp(1);
		check(irq, 1'b1);
		rdr(ADDR_STATUS);
		check(irq, 1'b0);
		rdr(8'hFC);
		check(rd, 32'h00000000);
	endtask : t_irq
	task t_rst_mid;
		int n;
		int c;
		@(posedge sys_clk);
		sys_rst <= 1'b1;
		repeat (2) @(posedge sys_clk);
		n = pulseCnt;
		repeat (300) @(posedge sys_clk);
		check(pulseCnt, n);
		check(|channelResults, 1'b0);
		sys_rst <= 1'b0;
		c = 0;
		while (pulseCnt == n && c < 2000) begin
			@(posedge sys_clk);
			c++;
		end
		check(c > 1020 && c < 1030, 1'b1);
		rdr(ADDR_SETUP);
		check(rd, 32'h0000000C);
	endtask : t_rst_mid
	initial begin
		repeat (12) @(posedge sys_clk);
		sys_rst <= 1'b0;
		t_rates();
		t_trims();
		t_irq();
		t_rst_mid();
		stop_test();
	end
endmodule : crd_rate_divider_tb_top
